// ---- hw/rx_dec_pkg.sv ----
// constants for the receive decimation and offset path
package rx_dec_pkg;
	localparam logic [7:0] ADDR_CHANNEL_SELECT    = 8'h05;
	localparam logic [7:0] ADDR_CHANNEL_OFFSET    = 8'h10;
	localparam logic [7:0] ADDR_FULLSCALE_ADJUST  = 8'h7D;
	localparam logic [7:0] ADDR_RX_TRIM_CONTROL   = 8'h7E;
	localparam logic [7:0] ADDR_UPDATE_STROBE     = 8'hFF;
	localparam logic [7:0] SEL_NORMAL             = 8'h00;
	localparam logic [7:0] SEL_I_CHANNEL          = 8'h01;
	localparam logic [7:0] SEL_Q_CHANNEL          = 8'h02;
	localparam int         OFFSET_BITS            = 6;
	localparam int         FULLSCALE_BITS         = 5;
	localparam int         CM_DISABLE_BIT         = 1;
	localparam int         UPDATE_BIT             = 0;
	localparam logic [7:0] CHANNEL_SELECT_RESET   = 8'h00;
	localparam logic [7:0] FULLSCALE_ADJUST_RESET = 8'h00;
	localparam logic [7:0] RX_TRIM_CONTROL_RESET  = 8'h00;
	localparam int         HB_TAPS                = 43;
	localparam int         HB_PAIRS               = 11;
	localparam int         HB_CENTRE_IDX          = 21;
	localparam int         HB_SHIFT               = 15;
	localparam int         ACC_BITS               = 34;
	localparam logic signed [15:0] HB_CENTRE      = 16'sh4000;
	localparam logic signed [15:0] HB_COEF [0:HB_PAIRS-1] = '{
		16'sh000C, -16'sh0020, 16'sh0048, -16'sh008C, 16'sh00FC, -16'sh01A6,
		16'sh02AA, -16'sh043E, 16'sh06F2, -16'sh0CD4, 16'sh287C};
endpackage

// ---- hw/rx_decimation_offset_path.sv ----
// receive path: half-band 2x decimator and per-channel digital offset
// Summary of operation
// - I and Q each have a bypassable half-band filter that halves the sample rate.
// - The filter is a symmetric half-band FIR with 11 even-index tap pairs 12..10364 and centre 16384.
// - Each channel keeps its own digital offset, added to its converter data.
// - The offset is a 6-bit value added directly at the LSBs of the output word.
// - The host selects a channel in channel_select, then writes channel_offset for it.
// - channel_select 0x01 steers offset accesses to the I channel.
// - channel_select 0x02 steers offset accesses to the Q channel.
// - Offset codes are two's complement, so 0xFE is -2 and 0x06 is +6.
// - Staged offsets reach the data path only when a value with bit 0 set is written to update_strobe.
// - Writing 0x00 to channel_select restores normal non-indexed addressing.
// - One converter can be powered down and the output put in single-converter mode.
// - Both channels run on one converter clock and share sampling instants.
// - A 5-bit field in fullscale_adjust selects the input full-scale range.
// - Bit 1 of rx_trim_control set to one disables the input common-mode buffer.
// - The update transfer starts only on a 0-to-1 change of the update bit.
`timescale 1ns/1ps
module rx_decimation_offset_path #(
	parameter int DW = 12
) (
	input  wire logic                                  sys_clk_in,
	input  wire logic                                  rst_n_in,
	input  wire logic                                  reg_wr_en_in,
	input  wire logic                                  reg_rd_en_in,
	input  wire logic [7:0]                            reg_addr_in,
	input  wire logic [7:0]                            reg_wdata_in,
	output logic      [7:0]                            reg_rdata_out,
	input  wire logic                                  dec_bypass_in,
	input  wire logic                                  single_adc_in,
	input  wire logic                                  sample_valid_in,
	input  wire logic signed [DW-1:0]                  i_sample_in,
	input  wire logic signed [DW-1:0]                  q_sample_in,
	output logic                                       data_valid_out,
	output logic signed [DW-1:0]                       i_data_out,
	output logic signed [DW-1:0]                       q_data_out,
	output logic                                       q_powerdown_out,
	output logic [rx_dec_pkg::FULLSCALE_BITS-1:0]      fullscale_range_sel_out,
	output logic                                       cm_buffer_disable_out
);
	import rx_dec_pkg::*;

	localparam logic signed [DW-1:0] SAT_MAX = {1'b0, {(DW-1){1'b1}}};
	localparam logic signed [DW-1:0] SAT_MIN = {1'b1, {(DW-1){1'b0}}};

	function automatic logic signed [DW-1:0] sat(input logic signed [ACC_BITS-1:0] v);
		if (v > ACC_BITS'(SAT_MAX))
			return SAT_MAX;
		else if (v < ACC_BITS'(SAT_MIN))
			return SAT_MIN;
		else
			return v[DW-1:0];
	endfunction

	function automatic logic wr_hit(input logic [7:0] a);
		return reg_wr_en_in && (reg_addr_in == a);
	endfunction

	// register group
	logic [7:0]                   channel_select;
	logic [7:0]                   fullscale_adjust;
	logic [7:0]                   rx_trim_control;
	logic                         update_bit;
	logic [OFFSET_BITS-1:0]       i_stage;
	logic [OFFSET_BITS-1:0]       q_stage;
	logic [OFFSET_BITS-1:0]       i_channel_offset;
	logic [OFFSET_BITS-1:0]       q_channel_offset;
	logic [7:0]                   next_channel_select;
	logic [7:0]                   next_fullscale_adjust;
	logic [7:0]                   next_rx_trim_control;
	logic                         next_update_bit;
	logic [OFFSET_BITS-1:0]       next_i_stage;
	logic [OFFSET_BITS-1:0]       next_q_stage;
	logic [OFFSET_BITS-1:0]       next_i_channel_offset;
	logic [OFFSET_BITS-1:0]       next_q_channel_offset;
	logic [7:0]                   next_reg_rdata;
	logic                         update_rise;

	always_comb begin
		next_channel_select   = channel_select;
		next_fullscale_adjust = fullscale_adjust;
		next_rx_trim_control  = rx_trim_control;
		next_update_bit       = update_bit;
		next_i_stage          = i_stage;
		next_q_stage          = q_stage;
		next_i_channel_offset = i_channel_offset;
		next_q_channel_offset = q_channel_offset;
		next_reg_rdata        = reg_rdata_out;
		update_rise           = 1'b0;
		if (wr_hit(ADDR_CHANNEL_SELECT))
			next_channel_select = reg_wdata_in;
		if (wr_hit(ADDR_CHANNEL_OFFSET)) begin
			if (channel_select == SEL_I_CHANNEL)
				next_i_stage = reg_wdata_in[OFFSET_BITS-1:0];
			else if (channel_select == SEL_Q_CHANNEL)
				next_q_stage = reg_wdata_in[OFFSET_BITS-1:0];
		end
		if (wr_hit(ADDR_FULLSCALE_ADJUST))
			next_fullscale_adjust = reg_wdata_in;
		if (wr_hit(ADDR_RX_TRIM_CONTROL))
			next_rx_trim_control = reg_wdata_in;
		if (wr_hit(ADDR_UPDATE_STROBE)) begin
			next_update_bit = reg_wdata_in[UPDATE_BIT];
			// holding the bit high does not re-copy
			update_rise = reg_wdata_in[UPDATE_BIT] && !update_bit;
		end
		if (update_rise) begin
			next_i_channel_offset = i_stage;
			next_q_channel_offset = q_stage;
		end
		if (reg_rd_en_in) begin
			case (reg_addr_in)
				ADDR_CHANNEL_SELECT:   next_reg_rdata = channel_select;
				ADDR_CHANNEL_OFFSET: begin
					// unindexed offset reads return zero
					if (channel_select == SEL_I_CHANNEL)
						next_reg_rdata = {{(8-OFFSET_BITS){1'b0}}, i_stage};
					else if (channel_select == SEL_Q_CHANNEL)
						next_reg_rdata = {{(8-OFFSET_BITS){1'b0}}, q_stage};
					else
						next_reg_rdata = 8'h00;
				end
				ADDR_FULLSCALE_ADJUST: next_reg_rdata = fullscale_adjust;
				ADDR_RX_TRIM_CONTROL:  next_reg_rdata = rx_trim_control;
				ADDR_UPDATE_STROBE:    next_reg_rdata = {7'h00, update_bit};
				default:               next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			channel_select   <= CHANNEL_SELECT_RESET;
			fullscale_adjust <= FULLSCALE_ADJUST_RESET;
			rx_trim_control  <= RX_TRIM_CONTROL_RESET;
			update_bit       <= 1'b0;
			i_stage          <= '0;
			q_stage          <= '0;
			i_channel_offset <= '0;
			q_channel_offset <= '0;
			reg_rdata_out    <= 8'h00;
		end else begin
			channel_select   <= next_channel_select;
			fullscale_adjust <= next_fullscale_adjust;
			rx_trim_control  <= next_rx_trim_control;
			update_bit       <= next_update_bit;
			i_stage          <= next_i_stage;
			q_stage          <= next_q_stage;
			i_channel_offset <= next_i_channel_offset;
			q_channel_offset <= next_q_channel_offset;
			reg_rdata_out    <= next_reg_rdata;
		end
	end

	assign fullscale_range_sel_out = fullscale_adjust[FULLSCALE_BITS-1:0];
	assign cm_buffer_disable_out   = rx_trim_control[CM_DISABLE_BIT];

	// datapath group; one sample_valid_in strobe clocks both channels
	logic signed [DW-1:0]       dl_i [0:HB_TAPS-1];
	logic signed [DW-1:0]       dl_q [0:HB_TAPS-1];
	logic signed [DW-1:0]       next_dl_i [0:HB_TAPS-1];
	logic signed [DW-1:0]       next_dl_q [0:HB_TAPS-1];
	logic                       shifted;
	logic                       phase;
	logic                       filt_vld;
	logic signed [DW-1:0]       filt_i;
	logic signed [DW-1:0]       filt_q;
	logic                       next_phase;
	logic                       next_filt_vld;
	logic signed [DW-1:0]       next_filt_i;
	logic signed [DW-1:0]       next_filt_q;
	logic                       next_data_valid;
	logic signed [DW-1:0]       next_i_data;
	logic signed [DW-1:0]       next_q_data;
	logic signed [ACC_BITS-1:0] acc_i;
	logic signed [ACC_BITS-1:0] acc_q;

	always_comb begin
		for (int k = 0; k < HB_TAPS; k++) begin
			next_dl_i[k] = dl_i[k];
			next_dl_q[k] = dl_q[k];
		end
		if (sample_valid_in) begin
			next_dl_i[0] = i_sample_in;
			next_dl_q[0] = q_sample_in;
			for (int k = 1; k < HB_TAPS; k++) begin
				next_dl_i[k] = dl_i[k-1];
				next_dl_q[k] = dl_q[k-1];
			end
		end
		// folded symmetric pairs on even taps; odd taps other than the centre are zero
		acc_i = ACC_BITS'(HB_CENTRE) * ACC_BITS'(dl_i[HB_CENTRE_IDX]);
		acc_q = ACC_BITS'(HB_CENTRE) * ACC_BITS'(dl_q[HB_CENTRE_IDX]);
		for (int p = 0; p < HB_PAIRS; p++) begin
			acc_i = acc_i + ACC_BITS'(HB_COEF[p]) *
				(ACC_BITS'(dl_i[2*p]) + ACC_BITS'(dl_i[HB_TAPS-1-2*p]));
			acc_q = acc_q + ACC_BITS'(HB_COEF[p]) *
				(ACC_BITS'(dl_q[2*p]) + ACC_BITS'(dl_q[HB_TAPS-1-2*p]));
		end
		next_phase    = phase;
		next_filt_vld = 1'b0;
		next_filt_i   = filt_i;
		next_filt_q   = filt_q;
		if (shifted) begin
			if (dec_bypass_in) begin
				next_filt_vld = 1'b1;
				next_filt_i   = dl_i[0];
				next_filt_q   = dl_q[0];
			end else begin
				next_phase    = !phase;
				next_filt_vld = phase;
				if (phase) begin
					next_filt_i = sat(acc_i >>> HB_SHIFT);
					next_filt_q = sat(acc_q >>> HB_SHIFT);
				end
			end
		end
		next_data_valid = filt_vld;
		next_i_data     = i_data_out;
		next_q_data     = q_data_out;
		if (filt_vld) begin
			// signed offset sign-extended into the LSBs, clipped at full scale
			next_i_data = sat(ACC_BITS'(filt_i) + ACC_BITS'($signed(i_channel_offset)));
			next_q_data = sat(ACC_BITS'(filt_q) + ACC_BITS'($signed(q_channel_offset)));
		end
		if (single_adc_in)
			next_q_data = '0;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int k = 0; k < HB_TAPS; k++) begin
				dl_i[k] <= '0;
				dl_q[k] <= '0;
			end
			shifted         <= 1'b0;
			phase           <= 1'b0;
			filt_vld        <= 1'b0;
			filt_i          <= '0;
			filt_q          <= '0;
			data_valid_out  <= 1'b0;
			i_data_out      <= '0;
			q_data_out      <= '0;
			q_powerdown_out <= 1'b0;
		end else begin
			dl_i            <= next_dl_i;
			dl_q            <= next_dl_q;
			shifted         <= sample_valid_in;
			phase           <= next_phase;
			filt_vld        <= next_filt_vld;
			filt_i          <= next_filt_i;
			filt_q          <= next_filt_q;
			data_valid_out  <= next_data_valid;
			i_data_out      <= next_i_data;
			q_data_out      <= next_q_data;
			q_powerdown_out <= single_adc_in;
		end
	end

	sequence s_rise;
		wr_hit(ADDR_UPDATE_STROBE) && reg_wdata_in[UPDATE_BIT] && !update_bit;
	endsequence
	sequence s_copied;
		##1 (i_channel_offset == $past(i_stage)) && (q_channel_offset == $past(q_stage));
	endsequence
	property p_update_copy;
		@(posedge sys_clk_in) disable iff (!rst_n_in) s_rise |-> s_copied;
	endproperty
	a_update_copy: assert property (p_update_copy) else $error("update did not copy offsets");
	property p_update_hold;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			update_bit && !(wr_hit(ADDR_UPDATE_STROBE) && !reg_wdata_in[UPDATE_BIT])
			|=> $stable(i_channel_offset) && $stable(q_channel_offset);
	endproperty
	a_update_hold: assert property (p_update_hold) else $error("offsets changed without edge");
	property p_sel_i;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_hit(ADDR_CHANNEL_OFFSET) && channel_select == SEL_I_CHANNEL
			|=> i_stage == $past(reg_wdata_in[OFFSET_BITS-1:0]) && $stable(q_stage);
	endproperty
	a_sel_i: assert property (p_sel_i) else $error("I offset write misdirected");
	property p_sel_q;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_hit(ADDR_CHANNEL_OFFSET) && channel_select == SEL_Q_CHANNEL
			|=> q_stage == $past(reg_wdata_in[OFFSET_BITS-1:0]) && $stable(i_stage);
	endproperty
	a_sel_q: assert property (p_sel_q) else $error("Q offset write misdirected");
	property p_bypass_rate;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			sample_valid_in && dec_bypass_in ##1 dec_bypass_in |=> filt_vld && filt_i == $past(dl_i[0]);
	endproperty
	a_bypass_rate: assert property (p_bypass_rate) else $error("bypass sample lost");
	property p_decimate;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			shifted && !dec_bypass_in |=> filt_vld == $past(phase) ##1 data_valid_out == $past(filt_vld);
	endproperty
	a_decimate: assert property (p_decimate) else $error("decimation phase wrong");
	property p_offset_add;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			filt_vld |=> data_valid_out &&
			i_data_out == sat(ACC_BITS'($past(filt_i)) + ACC_BITS'($signed($past(i_channel_offset))));
	endproperty
	a_offset_add: assert property (p_offset_add) else $error("I offset sum wrong");
	property p_single;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			single_adc_in |=> q_powerdown_out && q_data_out == '0;
	endproperty
	a_single: assert property (p_single) else $error("single mode not applied");
	property p_fullscale;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_hit(ADDR_FULLSCALE_ADJUST) |=> fullscale_range_sel_out == $past(reg_wdata_in[4:0]);
	endproperty
	a_fullscale: assert property (p_fullscale) else $error("full-scale field not stored");
	property p_cm_buffer;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_hit(ADDR_RX_TRIM_CONTROL) |=> cm_buffer_disable_out == $past(reg_wdata_in[1]);
	endproperty
	a_cm_buffer: assert property (p_cm_buffer) else $error("cm buffer bit wrong");
endmodule

// ---- dv/rx_baseband_model.sv ----
// baseband receiver model that captures each decimated word pair
`timescale 1ns/1ps
module rx_baseband_model #(
	parameter int DW = 12
) (
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 data_valid_in,
	input  wire logic signed [DW-1:0] i_data_in,
	input  wire logic signed [DW-1:0] q_data_in,
	output logic signed [DW-1:0]      last_i_out,
	output logic signed [DW-1:0]      last_q_out,
	output logic [15:0]               word_count_out
);
	// no back-pressure exists, so every valid word must be taken
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			last_i_out <= '0;
			last_q_out <= '0;
			word_count_out <= 16'h0000;
		end else if (data_valid_in) begin
			last_i_out <= i_data_in;
			last_q_out <= q_data_in;
			word_count_out <= word_count_out + 16'h0001;
		end
	end
endmodule

// ---- dv/rx_decimation_offset_path_tb.sv ----
// self-checking bench for the receive decimation and offset path
`timescale 1ns/1ps
module rx_decimation_offset_path_tb;
	import rx_dec_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic byp = 1'b1, single = 1'b0, svld = 1'b0, dvld, q_pd, cm_dis;
	logic signed [11:0] i_in = '0, q_in = '0, i_out, q_out, cap_i, cap_q;
	logic [FULLSCALE_BITS-1:0] fs_sel;
	logic [15:0] words;
	int bad_count = 0, n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	rx_decimation_offset_path #(.DW(12)) u_dut (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_wr_en_in(wr_en),
		.reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .dec_bypass_in(byp), .single_adc_in(single),
		.sample_valid_in(svld), .i_sample_in(i_in), .q_sample_in(q_in),
		.data_valid_out(dvld), .i_data_out(i_out), .q_data_out(q_out),
		.q_powerdown_out(q_pd), .fullscale_range_sel_out(fs_sel),
		.cm_buffer_disable_out(cm_dis));

	rx_baseband_model #(.DW(12)) u_bb (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .data_valid_in(dvld),
		.i_data_in(i_out), .q_data_in(q_out), .last_i_out(cap_i),
		.last_q_out(cap_q), .word_count_out(words));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset();
		@(negedge sys_clk) rst_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk) {wr_en, addr, wdata} = {1'b1, a, d};
		@(negedge sys_clk) wr_en = 1'b0;
	endtask

	// read data lands after the taking edge and then holds
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk) {rd_en, addr} = {1'b1, a};
		@(negedge sys_clk) rd_en = 1'b0;
		@(negedge sys_clk) chk(rdata, exp);
	endtask

	// one sample; the word pair must appear two edges after the taking edge
	task automatic samp(input logic signed [11:0] i, q, ei, eq);
		@(negedge sys_clk) {svld, i_in, q_in} = {1'b1, i, q};
		@(negedge sys_clk) svld = 1'b0;
		@(negedge sys_clk);
		chk(dvld, 1'b0);
		@(negedge sys_clk) chk(dvld, 1'b1);
		chk(i_out, ei);
		chk(q_out, eq);
	endtask

	task automatic t_regs();
		rd(ADDR_CHANNEL_SELECT, 8'h00);
		rd(ADDR_FULLSCALE_ADJUST, 8'h00);
		wr(8'h33, 8'hAA);
		rd(8'h33, 8'h00);
		wr(ADDR_FULLSCALE_ADJUST, 8'h1F);
		chk(fs_sel, 5'h1F);
		rd(ADDR_FULLSCALE_ADJUST, 8'h1F);
		wr(ADDR_RX_TRIM_CONTROL, 8'h02);
		chk(cm_dis, 1'b1);
		wr(ADDR_RX_TRIM_CONTROL, 8'h01);
		chk(cm_dis, 1'b0);
	endtask

	task automatic t_offset();
		samp(12'sd100, 12'sd100, 12'sd100, 12'sd100);
		wr(ADDR_CHANNEL_SELECT, SEL_I_CHANNEL);
		wr(ADDR_CHANNEL_OFFSET, 8'h06);
		wr(ADDR_CHANNEL_SELECT, SEL_Q_CHANNEL);
		wr(ADDR_CHANNEL_OFFSET, 8'hFE);
		rd(ADDR_CHANNEL_OFFSET, 8'h3E);
		wr(ADDR_CHANNEL_SELECT, SEL_I_CHANNEL);
		rd(ADDR_CHANNEL_OFFSET, 8'h06);
		samp(12'sd100, 12'sd100, 12'sd100, 12'sd100);
		wr(ADDR_UPDATE_STROBE, 8'h01);
		rd(ADDR_UPDATE_STROBE, 8'h01);
		samp(12'sd100, 12'sd100, 12'sd106, 12'sd98);
		samp(12'sd2045, -12'sd2047, 12'sd2047, -12'sd2048);
	endtask

	task automatic t_update_edge();
		wr(ADDR_CHANNEL_OFFSET, 8'h03);
		wr(ADDR_UPDATE_STROBE, 8'h01);
		samp(12'sd0, 12'sd0, 12'sd6, -12'sd2);
		wr(ADDR_UPDATE_STROBE, 8'h00);
		wr(ADDR_UPDATE_STROBE, 8'h01);
		samp(12'sd0, 12'sd0, 12'sd3, -12'sd2);
	endtask

	task automatic t_normal_addr();
		wr(ADDR_CHANNEL_SELECT, SEL_NORMAL);
		wr(ADDR_CHANNEL_OFFSET, 8'h15);
		rd(ADDR_CHANNEL_OFFSET, 8'h00);
		wr(ADDR_CHANNEL_SELECT, SEL_I_CHANNEL);
		rd(ADDR_CHANNEL_OFFSET, 8'h03);
		wr(ADDR_CHANNEL_SELECT, SEL_NORMAL);
	endtask

	// dc gain is 32776/32768, so 1000 stays 1000 and -1000 floors to -1001
	task automatic t_filter();
		byp = 1'b0;
		do_reset();
		for (int k = 0; k < 100; k++) begin
			@(negedge sys_clk) {svld, i_in, q_in} = {1'b1, 12'sd1000, -12'sd1000};
		end
		@(negedge sys_clk) svld = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(words, 16'd50);
		chk(cap_i, 12'sd1000);
		chk(cap_q, -12'sd1001);
	endtask

	task automatic t_single();
		byp = 1'b1;
		single = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(q_pd, 1'b1);
		samp(12'sd500, 12'sd700, 12'sd500, 12'sd0);
		single = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(q_pd, 1'b0);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		do_reset();
		t_regs();
		t_offset();
		t_update_edge();
		t_normal_addr();
		t_filter();
		t_single();
		print_verdict();
	end
endmodule
